/* src/discovery_param_table_rom.sv */
// streaming read port over the discovery parameter slice
`timescale 1ns/1ps
module discovery_param_table_rom (
    // clock, reset, enable
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic       clk_en_in,
    // variant strap
    input  wire logic       enhanced_latency_table_in,
    // read request
    input  wire logic       rd_start_in,
    input  wire logic       rd_space_in,
    input  wire logic [7:0] rd_offset_in,
    input  wire logic       rd_next_in,
    // read answer
    output logic [7:0]      rd_data_out,
    output logic            rd_valid_out,
    output logic            rd_in_slice_out,
    output logic [7:0]      rd_vendor_offset_out,
    output logic            rd_cycle_byte_out,
    output logic [2:0]      rd_mode_cycles_out,
    output logic [4:0]      rd_dummy_cycles_out,
    // status
    output logic            strap_ready_out,
    output logic            variant_out
);

    logic [7:0] ptr_r;
    logic       strap_r;
    logic       ready_r;
    logic [7:0] look_off;
    logic [7:0] look_byte;
    logic       look_hit;
    logic       take_start;
    logic       take_next;

    // bytes carrying mode and dummy fields
    function automatic logic is_cycle_byte(input logic [7:0] off);
        is_cycle_byte = (off == dpt_pkg::OFF_DOUT_CYC) ||
                        (off == dpt_pkg::OFF_DIO_CYC)  ||
                        (off == dpt_pkg::OFF_DALL_CYC);
    endfunction

    function automatic logic [7:0] to_vendor(input logic sp, input logic [7:0] off);
        logic [8:0] sum;
        sum = {1'b0, off} + {1'b0, dpt_pkg::DISC_TO_VENDOR};
        to_vendor = sp ? sum[7:0] : off;
    endfunction

    // start wins over next; nothing taken before the strap is caught
    assign take_start = clk_en_in && ready_r && rd_start_in;
    assign take_next  = clk_en_in && ready_r && !rd_start_in && rd_next_in;
    assign look_off   = rd_start_in ? to_vendor(rd_space_in, rd_offset_in) : ptr_r;

    param_byte_lookup u_lookup (
        .vendor_off_in             (look_off),
        .enhanced_latency_table_in (strap_r),
        .byte_out                  (look_byte),
        .hit_out                   (look_hit)
    );

    // strap caught once after reset release, so the table cannot change mid-read
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_r <= 1'b0;
            ready_r <= 1'b0;
        end else if (clk_en_in && !ready_r) begin
            strap_r <= enhanced_latency_table_in;
            ready_r <= 1'b1;
        end
    end

    // auto-increment pointer; wraps at 8 bits
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ptr_r <= 8'h00;
        end else if (take_start || take_next) begin
            ptr_r <= look_off + 8'h01;
        end
    end

    // answer registers; loaded only on a read, valid updated on every enabled edge
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out          <= dpt_pkg::RESERVED_FILLER;
            rd_valid_out         <= 1'b0;
            rd_in_slice_out      <= 1'b0;
            rd_vendor_offset_out <= 8'h00;
            rd_cycle_byte_out    <= 1'b0;
            rd_mode_cycles_out   <= 3'b000;
            rd_dummy_cycles_out  <= 5'b0_0000;
        end else if (clk_en_in) begin
            rd_valid_out <= take_start || take_next;
            if (take_start || take_next) begin
                rd_data_out          <= look_byte;
                rd_in_slice_out      <= look_hit;
                rd_vendor_offset_out <= look_off;
                rd_cycle_byte_out    <= is_cycle_byte(look_off);
                rd_mode_cycles_out   <= is_cycle_byte(look_off)
                    ? look_byte[7:dpt_pkg::MODE_LSB] : 3'b000;
                rd_dummy_cycles_out  <= is_cycle_byte(look_off)
                    ? look_byte[dpt_pkg::DUMMY_MSB:0] : 5'b0_0000;
            end
        end
    end

    // status mirrors
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_ready_out <= 1'b0;
            variant_out     <= 1'b0;
        end else if (clk_en_in) begin
            strap_ready_out <= ready_r;
            variant_out     <= strap_r;
        end
    end

endmodule

/* src/dpt_pkg.sv */
// constants for the discovery parameter table slice
// What this block does
// - the parameter block opens with identifier byte A5h at vendor offset 00h
// - vendor offset 0Dh (discovery 0Bh) returns quad-output read opcode 6Bh
// - vendor offset 0Eh (discovery 0Ch) returns 08h: no mode, eight dummy cycles
// - vendor offset 0Fh (discovery 0Dh) returns dual-output read opcode 3Bh
// - vendor offset 10h returns 80h for enhanced table, 04h for standard table
// - vendor offset 11h (discovery 0Fh) returns dual-I/O read opcode BBh
// - vendor offset 12h returns EEh: all-quad and all-dual unsupported, reserved ones
// - vendor offsets 13h to 15h return reserved filler FFh
// - vendor offsets 16h and 17h return reserved filler FFh
// - vendor offset 18h returns FFh: all-dual mode 111b, dummy 11111b
package dpt_pkg;

    localparam int unsigned MODE_LSB  = 5;
    localparam int unsigned DUMMY_MSB = 4;
    localparam int unsigned QUAD_ALL_BIT = 4;
    localparam int unsigned DUAL_ALL_BIT = 0;

    // vendor-space offsets
    localparam logic [7:0] OFF_ID          = 8'h00;
    localparam logic [7:0] OFF_QOUT_OPC    = 8'h0D;
    localparam logic [7:0] OFF_DOUT_CYC    = 8'h0E;
    localparam logic [7:0] OFF_DOUT_OPC    = 8'h0F;
    localparam logic [7:0] OFF_DIO_CYC     = 8'h10;
    localparam logic [7:0] OFF_DIO_OPC     = 8'h11;
    localparam logic [7:0] OFF_ALL_SUPPORT = 8'h12;
    localparam logic [7:0] OFF_FILL_A_LO   = 8'h13;
    localparam logic [7:0] OFF_FILL_A_HI   = 8'h15;
    localparam logic [7:0] OFF_FILL_B_LO   = 8'h16;
    localparam logic [7:0] OFF_FILL_B_HI   = 8'h17;
    localparam logic [7:0] OFF_DALL_CYC    = 8'h18;

    // discovery space sits this far below vendor space
    localparam logic [7:0] DISC_TO_VENDOR  = 8'h02;

    // cycle fields
    localparam logic [2:0] DOUT_MODE      = 3'b000;
    localparam logic [4:0] DOUT_DUMMY     = 5'b01000;
    localparam logic [2:0] DIO_MODE_ENH   = 3'b100;
    localparam logic [4:0] DIO_DUMMY_ENH  = 5'b00000;
    localparam logic [2:0] DIO_MODE_STD   = 3'b000;
    localparam logic [4:0] DIO_DUMMY_STD  = 5'b00100;
    localparam logic [2:0] DALL_MODE      = 3'b111;
    localparam logic [4:0] DALL_DUMMY     = 5'b11111;

    // byte values
    localparam logic [7:0] ID_BYTE         = 8'hA5;
    localparam logic [7:0] QOUT_OPCODE     = 8'h6B;
    localparam logic [7:0] DOUT_OPCODE     = 8'h3B;
    localparam logic [7:0] DIO_OPCODE      = 8'hBB;
    localparam logic [7:0] RESERVED_FILLER = 8'hFF;
    localparam logic [7:0] DOUT_CYC_BYTE   = {DOUT_MODE, DOUT_DUMMY};
    localparam logic [7:0] DIO_CYC_ENH     = {DIO_MODE_ENH, DIO_DUMMY_ENH};
    localparam logic [7:0] DIO_CYC_STD     = {DIO_MODE_STD, DIO_DUMMY_STD};
    localparam logic [7:0] DALL_CYC_BYTE   = {DALL_MODE, DALL_DUMMY};
    localparam logic [7:0] ALL_SUPPORT_BYTE = RESERVED_FILLER
        & ~(8'h01 << QUAD_ALL_BIT) & ~(8'h01 << DUAL_ALL_BIT);

endpackage

/* src/param_byte_lookup.sv */
// combinational byte lookup for the parameter slice
`timescale 1ns/1ps
module param_byte_lookup (
    // query
    input  wire logic [7:0] vendor_off_in,
    input  wire logic       enhanced_latency_table_in,
    // answer
    output logic [7:0]      byte_out,
    output logic            hit_out
);

    always_comb begin
        hit_out  = 1'b1;
        byte_out = dpt_pkg::RESERVED_FILLER;
        if (vendor_off_in == dpt_pkg::OFF_ID) begin
            byte_out = dpt_pkg::ID_BYTE;
        end else if (vendor_off_in == dpt_pkg::OFF_QOUT_OPC) begin
            byte_out = dpt_pkg::QOUT_OPCODE;
        end else if (vendor_off_in == dpt_pkg::OFF_DOUT_CYC) begin
            byte_out = dpt_pkg::DOUT_CYC_BYTE;
        end else if (vendor_off_in == dpt_pkg::OFF_DOUT_OPC) begin
            byte_out = dpt_pkg::DOUT_OPCODE;
        end else if (vendor_off_in == dpt_pkg::OFF_DIO_CYC) begin
            // only byte that depends on the variant
            byte_out = enhanced_latency_table_in ? dpt_pkg::DIO_CYC_ENH
                                                 : dpt_pkg::DIO_CYC_STD;
        end else if (vendor_off_in == dpt_pkg::OFF_DIO_OPC) begin
            byte_out = dpt_pkg::DIO_OPCODE;
        end else if (vendor_off_in == dpt_pkg::OFF_ALL_SUPPORT) begin
            byte_out = dpt_pkg::ALL_SUPPORT_BYTE;
        end else if (vendor_off_in >= dpt_pkg::OFF_FILL_A_LO &&
                     vendor_off_in <= dpt_pkg::OFF_FILL_A_HI) begin
            byte_out = dpt_pkg::RESERVED_FILLER;
        end else if (vendor_off_in >= dpt_pkg::OFF_FILL_B_LO &&
                     vendor_off_in <= dpt_pkg::OFF_FILL_B_HI) begin
            byte_out = dpt_pkg::RESERVED_FILLER;
        end else if (vendor_off_in == dpt_pkg::OFF_DALL_CYC) begin
            byte_out = dpt_pkg::DALL_CYC_BYTE;
        end else begin
            // outside the slice: filler, flagged as a miss
            hit_out = 1'b0;
        end
    end

endmodule

/* verification/discovery_param_table_rom_tb_top.sv */
// testbench for the discovery parameter slice
`timescale 1ns/1ps
module discovery_param_table_rom_tb_top;
    logic        clk_sys_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        clk_en_in  = 1'b1;
    logic        strap      = 1'b0;
    logic        strap_cap  = 1'b0;
    logic        en_edge    = 1'b0;
    logic        start, space, next, valid, slice, ready, variant;
    logic [7:0]  off, data, voff, ptr;
    logic [16:0] notes[$];
    int          fail_count = 0;
    int          n_compared = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    dpt_host_model host (.clk_in(clk_sys_in), .start_out(start), .space_out(space),
        .off_out(off), .next_out(next));
    discovery_param_table_rom dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in), .enhanced_latency_table_in(strap), .rd_start_in(start),
        .rd_space_in(space), .rd_offset_in(off), .rd_next_in(next), .rd_data_out(data),
        .rd_valid_out(valid), .rd_in_slice_out(slice), .rd_vendor_offset_out(voff),
        .rd_cycle_byte_out(), .rd_mode_cycles_out(), .rd_dummy_cycles_out(),
        .strap_ready_out(ready), .variant_out(variant));
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_b(input logic [7:0] a);
        case (a)
            8'h00: return 8'hA5;
            8'h0D: return 8'h6B;
            8'h0E: return 8'h08;
            8'h0F: return 8'h3B;
            8'h10: return strap_cap ? 8'h80 : 8'h04;
            8'h11: return 8'hBB;
            8'h12: return 8'hEE;
            default: return 8'hFF;
        endcase
    endfunction
    task automatic rd(input logic s, input logic sp, input logic [7:0] o, input logic n);
        logic [7:0] a;
        a = s ? (sp ? o + 8'h02 : o) : ptr;
        host.req(s, sp, o, n);
        if (s || n) begin
            notes.push_back({a == 8'h00 || (a >= 8'h0D && a <= 8'h18), a, exp_b(a)});
            ptr = a + 8'h01;
        end
    endtask
    always @(posedge clk_sys_in) begin
        // a frozen edge leaves valid up, so only enabled edges deliver
        en_edge = clk_en_in;
        #2;
        if (en_edge && valid === 1'b1)
            check({slice, voff, data}, notes.size() > 0 ? notes.pop_front() : 17'h0_0000);
    end
    task automatic conclude();
        if (fail_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #80000;
        fail_count++;
        conclude();
    end
    initial begin
        logic [7:0] r;
        void'($urandom(32'h87f0_29cb));
        strap = 1'($urandom());
        repeat (2) begin
            repeat (2) @(posedge clk_sys_in);
            #1 reset_n_in = 1'b1;
            // the strap is caught once, at the first enabled edge after release
            strap_cap = strap;
            repeat (2) @(posedge clk_sys_in);
            #3 check({15'h0000, ready, variant}, {15'h0000, 1'b1, strap});
            rd(1'b1, 1'b0, 8'h00, 1'b0);
            repeat (26) rd(1'b0, 1'b0, 8'h00, 1'b1);
            repeat (30) begin
                r = 8'($urandom());
                rd(1'b1, r[0], {3'b000, r[5:1]}, r[6]);
            end
            rd(1'b0, 1'b0, 8'h00, 1'b0);
            // frozen edge: request ignored, pointer kept
            clk_en_in = 1'b0;
            host.req(1'b1, 1'b0, 8'h0D, 1'b0);
            host.req(1'b0, 1'b0, 8'h00, 1'b0);
            clk_en_in = 1'b1;
            rd(1'b0, 1'b0, 8'h00, 1'b1);
            strap = ~strap;
            rd(1'b1, 1'b1, 8'h0E, 1'b0);
            rd(1'b0, 1'b0, 8'h00, 1'b0);
            @(posedge clk_sys_in);
            #1 reset_n_in = 1'b0;
        end
        conclude();
    end
endmodule

/* verification/dpt_host_model.sv */
// host model issuing table reads
`timescale 1ns/1ps
module dpt_host_model (
    // clock
    input  wire logic clk_in,
    // requests
    output logic       start_out,
    output logic       space_out,
    output logic [7:0] off_out,
    output logic       next_out
);
    initial {start_out, space_out, off_out, next_out} = 11'h000;
    // no ready on this port: every request lasts exactly one edge
    task automatic req(input logic s, input logic sp, input logic [7:0] o, input logic n);
        @(posedge clk_in);
        #1;
        {start_out, space_out, off_out, next_out} = {s, sp, o, n};
    endtask
endmodule

/* verification/dpt_rom_props.sv */
// assertions on the discovery parameter slice ports
`timescale 1ns/1ps
module dpt_rom_props (
    // clock, reset, enable
    input wire logic       clk_sys_in,
    input wire logic       reset_n_in,
    input wire logic       clk_en_in,
    // requests
    input wire logic       rd_start_in,
    input wire logic       rd_next_in,
    // answer and status
    input wire logic [7:0] rd_data_out,
    input wire logic       rd_valid_out,
    input wire logic [7:0] rd_vendor_offset_out,
    input wire logic       rd_cycle_byte_out,
    input wire logic [2:0] rd_mode_cycles_out,
    input wire logic [4:0] rd_dummy_cycles_out,
    input wire logic       strap_ready_out,
    input wire logic       variant_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    wire logic [7:0] o = rd_vendor_offset_out;
    wire logic       v = rd_valid_out;
    a_id_byte: assert property (v && o == 8'h00 |-> rd_data_out == 8'hA5)
        else $error("id byte wrong");
    a_quad_out_opc: assert property (v && o == 8'h0D |-> rd_data_out == 8'h6B)
        else $error("quad out opcode wrong");
    a_dual_out_cyc: assert property (v && o == 8'h0E |-> rd_data_out == 8'h08
        && rd_mode_cycles_out == 3'h0 && rd_dummy_cycles_out == 5'h08)
        else $error("dual out cycles");
    a_dual_out_opc: assert property (v && o == 8'h0F |-> rd_data_out == 8'h3B)
        else $error("dual out opcode wrong");
    a_dual_io_cyc: assert property (v && o == 8'h10 |-> rd_data_out ==
        (variant_out ? 8'h80 : 8'h04)) else $error("dual io cycles wrong");
    a_dual_io_fields: assert property (v && o == 8'h10 |-> rd_mode_cycles_out ==
        (variant_out ? 3'h4 : 3'h0) && rd_dummy_cycles_out == (variant_out ? 5'h00 : 5'h04))
        else $error("dual io fields wrong");
    a_dual_io_opc: assert property (v && o == 8'h11 |-> rd_data_out == 8'hBB)
        else $error("dual io opcode wrong");
    a_all_support: assert property (v && o == 8'h12 |-> rd_data_out == 8'hEE)
        else $error("support byte wrong");
    a_filler_low: assert property (v && o inside {[8'h13:8'h15]} |-> rd_data_out == 8'hFF)
        else $error("filler wrong");
    a_filler_high: assert property (v && o inside {8'h16, 8'h17} |-> rd_data_out == 8'hFF)
        else $error("filler wrong");
    a_dual_all_cyc: assert property (v && o == 8'h18 |-> rd_data_out == 8'hFF
        && rd_mode_cycles_out == 3'h7 && rd_dummy_cycles_out == 5'h1F) else $error("dual all");
    // host decodes fields only where this flag says so
    a_cycle_flag: assert property (v |-> rd_cycle_byte_out ==
        (o inside {8'h0E, 8'h10, 8'h18})) else $error("cycle flag wrong");
    // idle edge must drop valid and leave the answer data untouched
    a_no_side_effect: assert property (clk_en_in && !rd_start_in && !rd_next_in
        |=> !v && $stable(rd_data_out)) else $error("idle edge changed answer");
    a_strap_held: assert property (strap_ready_out |=> $stable(variant_out))
        else $error("strap changed");
endmodule
bind discovery_param_table_rom dpt_rom_props u_props (.clk_sys_in, .reset_n_in, .clk_en_in,
    .rd_start_in, .rd_next_in, .rd_data_out, .rd_valid_out, .rd_vendor_offset_out,
    .rd_cycle_byte_out, .rd_mode_cycles_out, .rd_dummy_cycles_out, .strap_ready_out,
    .variant_out);
